// >>> rtl/microcore_defs.svh
// designator codes, field widths and reset values of the operand decoder
`ifndef MICROCORE_DEFS_SVH
`define MICROCORE_DEFS_SVH

// -------------------------------------------------------------------------
// field widths
// -------------------------------------------------------------------------
`define ALU_W      3
`define CORE_W     5
`define CNT_SEL_W  2
`define REL_W      5
`define IMM_HALF_W 8
`define DRV_W      8

// -------------------------------------------------------------------------
// 3-bit alu and gpr/immediate set codes
// -------------------------------------------------------------------------
`define ALU_GPR0    3'h0
`define ALU_GPR1    3'h1
`define ALU_GPR2    3'h2
`define ALU_GPR3    3'h3
`define ALU_GPR4    3'h4
`define ALU_IMM     3'h5
`define ALU_PROD_HI 3'h6
`define ALU_PROD_LO 3'h7

// -------------------------------------------------------------------------
// 5-bit core set codes (00000..00111 reuse the alu set)
// -------------------------------------------------------------------------
`define CORE_ALU_TOP  2'h0
`define CORE_ALU_COND 5'h08
`define CORE_AUX      5'h09
`define CORE_JT1      5'h0A
`define CORE_JT2      5'h0B
`define CORE_CTR1     5'h0C
`define CORE_CTR2     5'h0D
`define CORE_CTR3     5'h0E
`define CORE_CTR4     5'h0F
`define CORE_LIM1     5'h10
`define CORE_LIM2     5'h11
`define CORE_LIM3     5'h12
`define CORE_LIM4     5'h13
`define CORE_FLAG     5'h14
`define CORE_CTRL     5'h15
`define CORE_STATUS   5'h16
`define CORE_BD_DATA  5'h17
`define CORE_DAC1     5'h18
`define CORE_DAC2     5'h19
`define CORE_DAC3     5'h1A
`define CORE_DAC4     5'h1B
`define CORE_DAC5     5'h1C
`define CORE_BD_ADDR  5'h1D
`define CORE_IRQ_STAT 5'h1E
`define CORE_CH_COMM  5'h1F

// -------------------------------------------------------------------------
// jump target set and reset values
// -------------------------------------------------------------------------
`define JT_SEL_ONE 1'b0
`define JT_SEL_TWO 1'b1
`define RST_REL    5'h00
`define RST_BYTE   8'h00
`define RST_DRV    8'h00

`endif

// >>> rtl/microcore_pkg.sv
// types and set decode functions shared by the operand decoder files
package microcore_pkg;
  `include "microcore_defs.svh"

  typedef enum logic [5:0] {
    REG_NONE, REG_GPR0, REG_GPR1, REG_GPR2, REG_GPR3, REG_GPR4,
    REG_IMMEDIATE_WORD, REG_PRODUCT_HIGH, REG_PRODUCT_LOW,
    REG_ALU_CONDITION_WORD, REG_AUX, REG_JUMP_TARGET_ONE, REG_JUMP_TARGET_TWO,
    REG_COUNTER_ONE, REG_COUNTER_TWO, REG_COUNTER_THREE, REG_COUNTER_FOUR,
    REG_END_COUNT_ONE, REG_END_COUNT_TWO, REG_END_COUNT_THREE, REG_END_COUNT_FOUR,
    REG_FLAG, REG_CONTROL_WORD, REG_STATUS_BITS_WORD, REG_BACKDOOR_DATA,
    REG_DAC1, REG_DAC2, REG_DAC3, REG_DAC4, REG_DAC5,
    REG_BACKDOOR_ADDR, REG_IRQ_STATUS, REG_CHANNEL_COMM
  } regId_t;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADDI, OP_MUL, OP_MULI, OP_AND, OP_IMM_LOAD_HIGH, OP_IMM_LOAD_LOW,
    OP_COPY, OP_JUMP_REL, OP_JUMP_FAR, OP_JUMP_TARGET_ONE_LOAD,
    OP_JUMP_TARGET_TWO_LOAD, OP_CNT_LOAD_ALU, OP_CNT_LOAD_RAM, OP_LOAD,
    OP_CALL_REL, OP_CALL_FAR, OP_IRET, OP_OTHER
  } opClass_t;

  typedef enum logic [2:0] {
    COND_ARITH, COND_CTRL, COND_FEEDBACK, COND_START, COND_STATUS,
    COND_CORE, COND_GENERIC, COND_ALWAYS
  } condFamily_t;

  typedef enum logic [1:0] {FN_NONE, FN_ADD, FN_MUL, FN_AND} aluFn_t;

  typedef struct packed {
    logic                   valid;
    logic                   illegal;
    regId_t                 srcA;
    regId_t                 srcB;
    regId_t                 dest;
    aluFn_t                 aluFn;
    logic                   prodWrite;
    logic                   immLoadHigh;
    logic                   immLoadLow;
    logic [`IMM_HALF_W-1:0] immByte;
    logic                   ramRead;
    logic                   counterLoad;
    logic                   driverSet;
    logic [`DRV_W-1:0]      driverBits;
    logic                   isJump;
    logic                   isCall;
    logic                   isReturn;
    logic                   targetFar;
    regId_t                 targetReg;
    logic [`REL_W-1:0]      relOffset;
    condFamily_t            condFamily;
  } state_t;

  function automatic regId_t aluSetDecode(input logic [`ALU_W-1:0] code);
    case (code)
      `ALU_GPR0:    aluSetDecode = REG_GPR0;
      `ALU_GPR1:    aluSetDecode = REG_GPR1;
      `ALU_GPR2:    aluSetDecode = REG_GPR2;
      `ALU_GPR3:    aluSetDecode = REG_GPR3;
      `ALU_GPR4:    aluSetDecode = REG_GPR4;
      `ALU_IMM:     aluSetDecode = REG_IMMEDIATE_WORD;
      `ALU_PROD_HI: aluSetDecode = REG_PRODUCT_HIGH;
      default:      aluSetDecode = REG_PRODUCT_LOW;
    endcase
  endfunction

  // product words are not reachable through this set
  function automatic regId_t gprImmDecode(input logic [`ALU_W-1:0] code);
    if (code > `ALU_IMM) begin
      gprImmDecode = REG_NONE;
    end else begin
      gprImmDecode = aluSetDecode(code);
    end
  endfunction

  function automatic regId_t jumpTargetDecode(input logic sel);
    jumpTargetDecode = (sel == `JT_SEL_TWO) ? REG_JUMP_TARGET_TWO : REG_JUMP_TARGET_ONE;
  endfunction
endpackage

// >>> rtl/core_operand_map.sv
// combinational map of a 5-bit core set designator onto a register
`timescale 1ns/1ps
`include "microcore_defs.svh"
module core_operand_map (
  input  wire logic [`CORE_W-1:0] code,
  output microcore_pkg::regId_t   regSel,
  output logic                    isCounter,
  output logic                    isDac
);
  import microcore_pkg::*;

  always_comb begin
    isCounter = 1'b0;
    isDac     = 1'b0;
    regSel    = REG_NONE;
    if (code[4:3] == `CORE_ALU_TOP) begin
      regSel = aluSetDecode(code[2:0]);
    end else begin
      case (code)
        `CORE_ALU_COND: regSel = REG_ALU_CONDITION_WORD;
        `CORE_AUX:      regSel = REG_AUX;
        `CORE_JT1:      regSel = REG_JUMP_TARGET_ONE;
        `CORE_JT2:      regSel = REG_JUMP_TARGET_TWO;
        `CORE_CTR1:     regSel = REG_COUNTER_ONE;
        `CORE_CTR2:     regSel = REG_COUNTER_TWO;
        `CORE_CTR3:     regSel = REG_COUNTER_THREE;
        `CORE_CTR4:     regSel = REG_COUNTER_FOUR;
        `CORE_LIM1:     regSel = REG_END_COUNT_ONE;
        `CORE_LIM2:     regSel = REG_END_COUNT_TWO;
        `CORE_LIM3:     regSel = REG_END_COUNT_THREE;
        `CORE_LIM4:     regSel = REG_END_COUNT_FOUR;
        `CORE_FLAG:     regSel = REG_FLAG;
        `CORE_CTRL:     regSel = REG_CONTROL_WORD;
        `CORE_STATUS:   regSel = REG_STATUS_BITS_WORD;
        `CORE_BD_DATA:  regSel = REG_BACKDOOR_DATA;
        `CORE_DAC1:     regSel = REG_DAC1;
        `CORE_DAC2:     regSel = REG_DAC2;
        `CORE_DAC3:     regSel = REG_DAC3;
        `CORE_DAC4:     regSel = REG_DAC4;
        `CORE_DAC5:     regSel = REG_DAC5;
        `CORE_BD_ADDR:  regSel = REG_BACKDOOR_ADDR;
        `CORE_IRQ_STAT: regSel = REG_IRQ_STATUS;
        `CORE_CH_COMM:  regSel = REG_CHANNEL_COMM;
        default:        regSel = REG_NONE;
      endcase
      isCounter = (code >= `CORE_CTR1) && (code <= `CORE_CTR4);
      isDac     = (code >= `CORE_DAC1) && (code <= `CORE_DAC5);
    end
  end
endmodule

// >>> rtl/microcore_operand_decoder.sv
// operand-field decoder and instruction classifier of the microcore
`timescale 1ns/1ps
`include "microcore_defs.svh"
module microcore_operand_decoder (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       insnValid,
  input  wire microcore_pkg::opClass_t    opClass,
  input  wire microcore_pkg::condFamily_t condIn,
  input  wire logic [`ALU_W-1:0]          aluOpA,
  input  wire logic [`ALU_W-1:0]          aluOpB,
  input  wire logic [`ALU_W-1:0]          aluRes,
  input  wire logic [`ALU_W-1:0]          gprImmSel,
  input  wire logic [`CORE_W-1:0]         coreSrc,
  input  wire logic [`CORE_W-1:0]         coreDst,
  input  wire logic                       jumpSel,
  input  wire logic [`CNT_SEL_W-1:0]      cntSel,
  input  wire logic [`REL_W-1:0]          relIn,
  input  wire logic [`IMM_HALF_W-1:0]     immIn,
  input  wire logic [`DRV_W-1:0]          driverIn,
  output logic                            decValid,
  output logic                            decIllegal,
  output microcore_pkg::regId_t           srcA,
  output microcore_pkg::regId_t           srcB,
  output microcore_pkg::regId_t           dest,
  output microcore_pkg::aluFn_t           aluFn,
  output logic                            prodWrite,
  output logic                            immLoadHigh,
  output logic                            immLoadLow,
  output logic [`IMM_HALF_W-1:0]          immByte,
  output logic                            ramRead,
  output logic                            counterLoad,
  output logic                            driverSet,
  output logic [`DRV_W-1:0]               driverBits,
  output logic                            isJump,
  output logic                            isCall,
  output logic                            isReturn,
  output logic                            targetFar,
  output microcore_pkg::regId_t           targetReg,
  output logic [`REL_W-1:0]               relOffset,
  output microcore_pkg::condFamily_t      condFamily
);
  import microcore_pkg::*;

  // -----------------------------------------------------------------------
  // core set maps for the copy source and destination
  // -----------------------------------------------------------------------
  regId_t coreSrcReg;
  regId_t coreDstReg;

  core_operand_map srcMap (
    .code      (coreSrc),
    .regSel    (coreSrcReg),
    .isCounter (),
    .isDac     ()
  );

  core_operand_map dstMap (
    .code      (coreDst),
    .regSel    (coreDstReg),
    .isCounter (),
    .isDac     ()
  );

  // -----------------------------------------------------------------------
  // counter selection for the counter-load family
  // -----------------------------------------------------------------------
  function automatic regId_t counterDecode(input logic [`CNT_SEL_W-1:0] sel);
    case (sel)
      2'h0:    counterDecode = REG_COUNTER_ONE;
      2'h1:    counterDecode = REG_COUNTER_TWO;
      2'h2:    counterDecode = REG_COUNTER_THREE;
      default: counterDecode = REG_COUNTER_FOUR;
    endcase
  endfunction

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  state_t s_q;
  state_t s_d;
  regId_t aluA;
  regId_t aluB;
  regId_t aluR;
  regId_t gprImm;

  assign aluA   = aluSetDecode(aluOpA);
  assign aluB   = aluSetDecode(aluOpB);
  assign aluR   = aluSetDecode(aluRes);
  assign gprImm = gprImmDecode(gprImmSel);

  // -----------------------------------------------------------------------
  // classification
  // -----------------------------------------------------------------------
  always_comb begin
    s_d             = '0;
    s_d.srcA        = REG_NONE;
    s_d.srcB        = REG_NONE;
    s_d.dest        = REG_NONE;
    s_d.targetReg   = REG_NONE;
    s_d.aluFn       = FN_NONE;
    s_d.condFamily  = COND_ALWAYS;
    s_d.immByte     = s_q.immByte;
    s_d.driverBits  = s_q.driverBits;
    s_d.relOffset   = s_q.relOffset;
    s_d.valid       = insnValid;

    if (insnValid) begin
      case (opClass)
        OP_ADD: begin
          s_d.srcA  = aluA;
          s_d.srcB  = aluB;
          s_d.dest  = aluR;
          s_d.aluFn = FN_ADD;
        end

        OP_ADDI: begin
          s_d.srcA  = aluA;
          s_d.srcB  = REG_IMMEDIATE_WORD;
          s_d.dest  = aluR;
          s_d.aluFn = FN_ADD;
        end

        OP_MUL: begin
          s_d.srcA      = aluA;
          s_d.srcB      = aluB;
          s_d.dest      = REG_PRODUCT_HIGH;
          s_d.aluFn     = FN_MUL;
          s_d.prodWrite = 1'b1;
        end

        OP_MULI: begin
          s_d.srcA      = aluA;
          s_d.srcB      = REG_IMMEDIATE_WORD;
          s_d.dest      = REG_PRODUCT_HIGH;
          s_d.aluFn     = FN_MUL;
          s_d.prodWrite = 1'b1;
        end

        OP_AND: begin
          s_d.srcA  = aluA;
          s_d.srcB  = REG_IMMEDIATE_WORD;
          s_d.dest  = aluR;
          s_d.aluFn = FN_AND;
        end

        OP_IMM_LOAD_HIGH: begin
          s_d.dest        = REG_IMMEDIATE_WORD;
          s_d.immLoadHigh = 1'b1;
          s_d.immByte     = immIn;
        end

        OP_IMM_LOAD_LOW: begin
          s_d.dest       = REG_IMMEDIATE_WORD;
          s_d.immLoadLow = 1'b1;
          s_d.immByte    = immIn;
        end

        OP_COPY: begin
          s_d.srcA = coreSrcReg;
          s_d.dest = coreDstReg;
        end

        OP_JUMP_REL: begin
          s_d.isJump     = 1'b1;
          s_d.condFamily = condIn;
          s_d.relOffset  = relIn;
        end

        OP_JUMP_FAR: begin
          s_d.isJump     = 1'b1;
          s_d.condFamily = condIn;
          s_d.targetFar  = 1'b1;
          s_d.targetReg  = jumpTargetDecode(jumpSel);
        end

        OP_JUMP_TARGET_ONE_LOAD: begin
          s_d.srcA = coreSrcReg;
          s_d.dest = REG_JUMP_TARGET_ONE;
        end

        OP_JUMP_TARGET_TWO_LOAD: begin
          s_d.srcA = coreSrcReg;
          s_d.dest = REG_JUMP_TARGET_TWO;
        end

        OP_CNT_LOAD_ALU: begin
          // a product code here has no register behind it
          s_d.srcA        = gprImm;
          s_d.dest        = counterDecode(cntSel);
          s_d.counterLoad = 1'b1;
          s_d.driverSet   = 1'b1;
          s_d.driverBits  = driverIn;
          s_d.illegal     = (gprImm == REG_NONE);
        end

        OP_CNT_LOAD_RAM: begin
          s_d.dest        = counterDecode(cntSel);
          s_d.ramRead     = 1'b1;
          s_d.counterLoad = 1'b1;
          s_d.driverSet   = 1'b1;
          s_d.driverBits  = driverIn;
        end

        OP_LOAD: begin
          s_d.dest    = coreDstReg;
          s_d.ramRead = 1'b1;
        end

        OP_CALL_REL: begin
          s_d.isCall    = 1'b1;
          s_d.relOffset = relIn;
        end

        OP_CALL_FAR: begin
          s_d.isCall    = 1'b1;
          s_d.targetFar = 1'b1;
          s_d.targetReg = jumpTargetDecode(jumpSel);
        end

        OP_IRET: begin
          s_d.isReturn = 1'b1;
        end

        OP_OTHER: begin
          // peripheral instructions pass through with no operand decode
          s_d.srcA = REG_NONE;
        end

        default: begin
          s_d.illegal = 1'b1;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // register
  // -----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.srcA       <= REG_NONE;
      s_q.srcB       <= REG_NONE;
      s_q.dest       <= REG_NONE;
      s_q.targetReg  <= REG_NONE;
      s_q.aluFn      <= FN_NONE;
      s_q.condFamily <= COND_ALWAYS;
      s_q.immByte    <= `RST_BYTE;
      s_q.driverBits <= `RST_DRV;
      s_q.relOffset  <= `RST_REL;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------------
  // outputs, all from the state register
  // -----------------------------------------------------------------------
  assign decValid    = s_q.valid;
  assign decIllegal  = s_q.illegal;

  assign srcA        = s_q.srcA;
  assign srcB        = s_q.srcB;
  assign dest        = s_q.dest;
  assign aluFn       = s_q.aluFn;

  assign prodWrite   = s_q.prodWrite;
  assign immLoadHigh = s_q.immLoadHigh;
  assign immLoadLow  = s_q.immLoadLow;
  assign immByte     = s_q.immByte;

  assign ramRead     = s_q.ramRead;
  assign counterLoad = s_q.counterLoad;
  assign driverSet   = s_q.driverSet;
  assign driverBits  = s_q.driverBits;

  assign isJump      = s_q.isJump;
  assign isCall      = s_q.isCall;
  assign isReturn    = s_q.isReturn;
  assign targetFar   = s_q.targetFar;
  assign targetReg   = s_q.targetReg;
  assign relOffset   = s_q.relOffset;
  assign condFamily  = s_q.condFamily;
endmodule

// >>> testbench/microcore_operand_decoder_asserts.sv
// bound port checks for the operand decoder
`timescale 1ns/1ps
`include "microcore_defs.svh"
module microcore_operand_decoder_asserts
  import microcore_pkg::*;
(
  input wire logic                   ref_clk, rst, insnValid, jumpSel,
  input wire opClass_t               opClass,
  input wire logic [`ALU_W-1:0]      aluRes, gprImmSel,
  input wire logic [`CORE_W-1:0]     coreSrc, coreDst,
  input wire logic [`REL_W-1:0]      relIn, relOffset,
  input wire logic [`IMM_HALF_W-1:0] immIn, immByte,
  input wire logic                   decValid, decIllegal, prodWrite, immLoadHigh, ramRead,
  input wire logic                   counterLoad, driverSet, isJump, isCall, isReturn, targetFar,
  input wire regId_t                 srcA, srcB, dest, targetReg,
  input wire aluFn_t                 aluFn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // register selection
  // ---------------------------------------------------------------
  // the register list follows designator order, so code + 1 names the register
  property p_add_dest;
    insnValid && opClass == OP_ADD |=> decValid && aluFn == FN_ADD
      && dest == regId_t'({3'b000, $past(aluRes)} + 6'h01);
  endproperty
  a_add_dest: assert property (p_add_dest) else $error("add result register wrong");
  property p_copy_regs;
    insnValid && opClass == OP_COPY |=> srcA == regId_t'({1'b0, $past(coreSrc)} + 6'h01)
      && dest == regId_t'({1'b0, $past(coreDst)} + 6'h01);
  endproperty
  a_copy_regs: assert property (p_copy_regs) else $error("copy registers wrong");
  property p_load_ram;
    insnValid && opClass == OP_LOAD |=> ramRead && !counterLoad
      && dest == regId_t'({1'b0, $past(coreDst)} + 6'h01);
  endproperty
  a_load_ram: assert property (p_load_ram) else $error("load decode wrong");
  property p_cnt_illegal;
    insnValid && opClass == OP_CNT_LOAD_ALU && gprImmSel > 3'h5
      |=> decIllegal && srcA == REG_NONE && counterLoad && driverSet;
  endproperty
  a_cnt_illegal: assert property (p_cnt_illegal) else $error("product code not refused");

  // ---------------------------------------------------------------
  // arithmetic and immediate
  // ---------------------------------------------------------------
  property p_mul_prod;
    insnValid && (opClass == OP_MUL || opClass == OP_MULI)
      |=> prodWrite && dest == REG_PRODUCT_HIGH && aluFn == FN_MUL;
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("multiply decode wrong");
  property p_and_mask;
    insnValid && opClass == OP_AND |-> ##1 srcB == REG_IMMEDIATE_WORD && aluFn == FN_AND && !prodWrite;
  endproperty
  a_and_mask: assert property (p_and_mask) else $error("and mask decode wrong");
  property p_imm_high;
    insnValid && opClass == OP_IMM_LOAD_HIGH |=> immLoadHigh && immByte == $past(immIn);
  endproperty
  a_imm_high: assert property (p_imm_high) else $error("immediate high load wrong");

  // ---------------------------------------------------------------
  // flow control
  // ---------------------------------------------------------------
  property p_far_target;
    insnValid && opClass == OP_JUMP_FAR |=> isJump && targetFar
      && targetReg == ($past(jumpSel) ? REG_JUMP_TARGET_TWO : REG_JUMP_TARGET_ONE);
  endproperty
  a_far_target: assert property (p_far_target) else $error("far jump target wrong");
  property p_rel_offset;
    insnValid && opClass == OP_JUMP_REL |=> isJump && !targetFar && relOffset == $past(relIn);
  endproperty
  a_rel_offset: assert property (p_rel_offset) else $error("relative jump wrong");
  property p_call_ret;
    insnValid && opClass inside {OP_CALL_REL, OP_CALL_FAR, OP_IRET} |=> !isJump
      && isReturn == ($past(opClass) == OP_IRET) && isCall == ($past(opClass) != OP_IRET);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("call or return wrong");
  property p_jt_load;
    insnValid && opClass == OP_JUMP_TARGET_TWO_LOAD |=> dest == REG_JUMP_TARGET_TWO;
  endproperty
  a_jt_load: assert property (p_jt_load) else $error("jump target load wrong");

  c_add: cover property (insnValid && opClass == OP_ADD ##1 decValid);
  c_far: cover property (insnValid && opClass == OP_JUMP_FAR && jumpSel);
  c_bad: cover property (decIllegal);
endmodule

bind microcore_operand_decoder microcore_operand_decoder_asserts i_microcore_operand_decoder_asserts (
  .ref_clk(ref_clk), .rst(rst), .insnValid(insnValid), .jumpSel(jumpSel), .opClass(opClass),
  .aluRes(aluRes), .gprImmSel(gprImmSel), .coreSrc(coreSrc), .coreDst(coreDst),
  .relIn(relIn), .relOffset(relOffset), .immIn(immIn), .immByte(immByte),
  .decValid(decValid), .decIllegal(decIllegal), .prodWrite(prodWrite),
  .immLoadHigh(immLoadHigh), .ramRead(ramRead), .counterLoad(counterLoad),
  .driverSet(driverSet), .isJump(isJump), .isCall(isCall), .isReturn(isReturn),
  .targetFar(targetFar), .srcA(srcA), .srcB(srcB), .dest(dest), .targetReg(targetReg),
  .aluFn(aluFn));

// >>> testbench/test_microcore_operand_decoder.sv
// self-checking random bench for the operand decoder
`timescale 1ns/1ps
`include "microcore_defs.svh"
module test_microcore_operand_decoder;
  import microcore_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, insnValid = 1'b0, jumpSel = 1'b0;
  opClass_t opClass = OP_OTHER;
  condFamily_t condIn = COND_ARITH;
  logic [`ALU_W-1:0] aluOpA = '0, aluOpB = '0, aluRes = '0, gprImmSel = '0;
  logic [`CORE_W-1:0] coreSrc = '0, coreDst = '0;
  logic [`CNT_SEL_W-1:0] cntSel = '0;
  logic [`REL_W-1:0] relIn = '0, lastRel = '0;
  logic [7:0] immIn = '0, driverIn = '0, lastImm = '0, lastDrv = '0;
  wire state_t got;
  int badCount = 0, nChecks = 0, cycles = 0;

  microcore_operand_decoder i_microcore_operand_decoder (
    .ref_clk(ref_clk), .rst(rst), .insnValid(insnValid), .opClass(opClass), .condIn(condIn),
    .aluOpA(aluOpA), .aluOpB(aluOpB), .aluRes(aluRes), .gprImmSel(gprImmSel),
    .coreSrc(coreSrc), .coreDst(coreDst), .jumpSel(jumpSel), .cntSel(cntSel), .relIn(relIn),
    .immIn(immIn), .driverIn(driverIn), .decValid(got.valid), .decIllegal(got.illegal),
    .srcA(got.srcA), .srcB(got.srcB), .dest(got.dest), .aluFn(got.aluFn),
    .prodWrite(got.prodWrite), .immLoadHigh(got.immLoadHigh), .immLoadLow(got.immLoadLow),
    .immByte(got.immByte), .ramRead(got.ramRead), .counterLoad(got.counterLoad),
    .driverSet(got.driverSet), .driverBits(got.driverBits), .isJump(got.isJump),
    .isCall(got.isCall), .isReturn(got.isReturn), .targetFar(got.targetFar),
    .targetReg(got.targetReg), .relOffset(got.relOffset), .condFamily(got.condFamily));

  always #5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // expectation
  // ---------------------------------------------------------------
  // register list follows the 5-bit designator order, so code + 1 names it
  function automatic regId_t coreReg(input logic [4:0] c);
    return regId_t'({1'b0, c} + 6'h01);
  endfunction

  function automatic state_t predict();
    state_t e;
    logic isAlu;
    e = '0;
    e.condFamily = COND_ALWAYS;
    // reset also clears the held bytes and offset
    if (rst) return e;
    e.immByte = lastImm;
    e.driverBits = lastDrv;
    e.relOffset = lastRel;
    if (!insnValid) return e;
    e.valid = 1'b1;
    isAlu = opClass inside {OP_ADD, OP_ADDI, OP_MUL, OP_MULI, OP_AND};
    if (isAlu) begin
      e.srcA = coreReg({2'b00, aluOpA});
      e.srcB = (opClass inside {OP_ADD, OP_MUL}) ? coreReg({2'b00, aluOpB}) : REG_IMMEDIATE_WORD;
      e.dest = coreReg({2'b00, aluRes});
      e.aluFn = (opClass == OP_AND) ? FN_AND : (opClass inside {OP_ADD, OP_ADDI}) ? FN_ADD : FN_MUL;
      e.prodWrite = opClass inside {OP_MUL, OP_MULI};
      if (e.prodWrite) e.dest = REG_PRODUCT_HIGH;
    end
    e.immLoadHigh = (opClass == OP_IMM_LOAD_HIGH);
    e.immLoadLow = (opClass == OP_IMM_LOAD_LOW);
    if (e.immLoadHigh || e.immLoadLow) begin
      e.immByte = immIn;
      e.dest = REG_IMMEDIATE_WORD;
    end
    if (opClass == OP_COPY) e.srcA = coreReg(coreSrc);
    if (opClass inside {OP_COPY, OP_LOAD}) e.dest = coreReg(coreDst);
    if (opClass inside {OP_JUMP_TARGET_ONE_LOAD, OP_JUMP_TARGET_TWO_LOAD}) begin
      e.srcA = coreReg(coreSrc);
      e.dest = (opClass == OP_JUMP_TARGET_TWO_LOAD) ? REG_JUMP_TARGET_TWO : REG_JUMP_TARGET_ONE;
    end
    e.counterLoad = opClass inside {OP_CNT_LOAD_ALU, OP_CNT_LOAD_RAM};
    e.driverSet = e.counterLoad;
    if (e.counterLoad) begin
      e.driverBits = driverIn;
      e.dest = regId_t'(REG_COUNTER_ONE + cntSel);
    end
    if (opClass == OP_CNT_LOAD_ALU) begin
      e.illegal = (gprImmSel > 3'h5);
      e.srcA = e.illegal ? REG_NONE : coreReg({2'b00, gprImmSel});
    end
    e.ramRead = opClass inside {OP_CNT_LOAD_RAM, OP_LOAD};
    e.isJump = opClass inside {OP_JUMP_REL, OP_JUMP_FAR};
    e.isCall = opClass inside {OP_CALL_REL, OP_CALL_FAR};
    e.isReturn = (opClass == OP_IRET);
    e.targetFar = opClass inside {OP_JUMP_FAR, OP_CALL_FAR};
    if (e.targetFar) e.targetReg = jumpSel ? REG_JUMP_TARGET_TWO : REG_JUMP_TARGET_ONE;
    if (opClass inside {OP_JUMP_REL, OP_CALL_REL}) e.relOffset = relIn;
    if (e.isJump) e.condFamily = condIn;
    return e;
  endfunction

  // ---------------------------------------------------------------
  // checking and driving
  // ---------------------------------------------------------------
  task automatic checkValue(input string what, input logic [63:0] seen, input logic [63:0] want);
    nChecks++;
    if (seen !== want) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  // one instruction per cycle, back to back; result compared a cycle later
  task automatic issue(input logic v, input opClass_t op);
    state_t e, g;
    insnValid = v;
    opClass = op;
    e = predict();
    @(negedge ref_clk);
    g = got;
    checkValue("decoded", 64'(g), 64'(e));
    lastImm = e.immByte;
    lastDrv = e.driverBits;
    lastRel = e.relOffset;
  endtask

  task automatic randomFields();
    {aluOpA, aluOpB, aluRes, gprImmSel} = 12'($urandom);
    {coreSrc, coreDst, cntSel, relIn, jumpSel} = 18'($urandom);
    {immIn, driverIn} = 16'($urandom);
    condIn = condFamily_t'($urandom_range(7, 0));
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // expected run is about 1700 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      badCount++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(14713));
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    issue(1'b0, OP_OTHER);
    // every class with every 3-bit code, including refused product codes
    for (int op = 0; op <= OP_OTHER; op++) begin
      for (int c = 0; c < 8; c++) begin
        randomFields();
        aluOpA = 3'(c);
        aluRes = 3'(7 - c);
        gprImmSel = 3'(c);
        jumpSel = c[0];
        issue(1'b1, opClass_t'(op));
      end
    end
    // whole 5-bit core set as source and destination
    for (int c = 0; c < 32; c++) begin
      randomFields();
      coreSrc = 5'(c);
      coreDst = 5'(31 - c);
      issue(1'b1, OP_COPY);
    end
    repeat (1500) begin
      randomFields();
      issue($urandom_range(3, 0) != 0, opClass_t'($urandom_range(OP_OTHER, 0)));
    end
    // reset in mid-run drops a taken load and clears held bytes
    randomFields();
    rst = 1'b1;
    issue(1'b1, OP_IMM_LOAD_LOW);
    rst = 1'b0;
    issue(1'b0, OP_OTHER);
    issue(1'b1, OP_JUMP_FAR);
    finish_test();
  end
endmodule
